// >>> hdl/sbt_timer.sv
// Behaviour
// - only power-on reset clears count and settings; other resets never reach it
// - sixteen-bit count as timer, synchronous counter or unsynchronised counter
// - interrupt on period match and on gate falling edge in gated mode
// - count while run_enable is one, hold while it is zero
// - keeps running in idle, and in sleep only as unsynchronised counter; stop_in_idle halts it in idle
// - extended select counts only while clock_source_select picks extended source
// - gating ignored with extended clock; else one counts only while gate high
// - prescale divides input by 1, 8, 64 or 256
// - sync bit synchronises extended clock; ignored with internal clock
`timescale 1ns/1ns
module sbt_timer (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [2:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out,
  input  wire logic        idle_in,
  input  wire logic        sleep_in,
  input  wire logic        secondary_osc_in,
  input  wire logic        external_clock_pin_in,
  input  wire logic        low_power_rc_osc_in,
  input  wire logic        gate_in,
  output logic             irq_out
);
  // ==========================================================
  // registers
  logic [15:0]          ctrl_ff;
  logic [15:0]          period_value_ff;
  logic [15:0]          count_ff;
  logic [1:0]           status_ff;
  logic [1:0]           mask_ff;
  logic [15:0]          rdata_ff;
  logic                 ext_rise_d_ff;
  sbt_pkg::sbt_state_t  state_ff;
  sbt_pkg::sbt_state_t  nxt_state;

  logic                 run_enable;
  logic                 stop_in_idle;
  sbt_pkg::sbt_ecs_t    extended_clock_select;
  logic                 gated_accumulate_enable;
  logic [1:0]           prescale_select;
  logic                 external_sync_select;
  logic                 clock_source_select;
  logic                 ext_rise;
  logic                 match;
  logic                 count_wr;
  logic                 ctrl_wr;
  logic [1:0]           ev_set;
  logic [1:0]           ev_clr;

  sbt_tick_if tk ();

  sbt_pin_sync u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .pins_in  ({gate_in, low_power_rc_osc_in, external_clock_pin_in, secondary_osc_in}),
    .tk       (tk)
  );

  sbt_prescaler u_presc (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .tk       (tk)
  );

  assign run_enable              = ctrl_ff[sbt_pkg::RUN_BIT];
  assign stop_in_idle            = ctrl_ff[sbt_pkg::IDLE_BIT];
  assign extended_clock_select   = sbt_pkg::sbt_ecs_t'(ctrl_ff[sbt_pkg::ECS_LSB +: 2]);
  assign gated_accumulate_enable = ctrl_ff[sbt_pkg::GATE_BIT];
  assign prescale_select         = ctrl_ff[sbt_pkg::PS_LSB +: 2];
  assign external_sync_select    = ctrl_ff[sbt_pkg::SYNC_BIT];
  assign clock_source_select     = ctrl_ff[sbt_pkg::CS_BIT];

  assign ctrl_wr  = wr_in && (addr_in == sbt_pkg::ADDR_CTRL);
  assign count_wr = wr_in && (addr_in == sbt_pkg::ADDR_COUNT);

  // ==========================================================
  // run state: hold covers idle stop and sleep
  // an unsynchronised extended counter is the only mode that survives sleep,
  // since the synchroniser and system clock tick are dead there
  always_comb begin
    case (state_ff)
      sbt_pkg::ST_OFF,
      sbt_pkg::ST_RUN,
      sbt_pkg::ST_HOLD: begin
        if (!run_enable) begin
          nxt_state = sbt_pkg::ST_OFF;
        end else if ((idle_in && stop_in_idle) ||
                     (sleep_in && !(clock_source_select && !external_sync_select))) begin
          nxt_state = sbt_pkg::ST_HOLD;
        end else begin
          nxt_state = sbt_pkg::ST_RUN;
        end
      end
      default: nxt_state = sbt_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= sbt_pkg::ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // clock source selection
  always_comb begin
    case (extended_clock_select)
      sbt_pkg::ECS_SECONDARY_OSC: ext_rise = tk.pin_rise[sbt_pkg::PIN_SECONDARY_OSC];
      sbt_pkg::ECS_PIN:  ext_rise = tk.pin_rise[sbt_pkg::PIN_EXT];
      sbt_pkg::ECS_LOW_POWER_RC_OSC: ext_rise = tk.pin_rise[sbt_pkg::PIN_LOW_POWER_RC_OSC];
      default:           ext_rise = 1'b0;
    endcase
  end

  // sync mode costs one extra cycle of latency to align to the device clock
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ext_rise_d_ff <= 1'b0;
    end else begin
      ext_rise_d_ff <= ext_rise;
    end
  end

  // the live run condition gates the tick too: without it a stop, idle stop or
  // sleep request would let one more tick through while the state register
  // catches up, and a halted timer must not move at all
  always_comb begin
    tk.src_tick = 1'b0;
    if ((state_ff == sbt_pkg::ST_RUN) && (nxt_state == sbt_pkg::ST_RUN)) begin
      if (clock_source_select) begin
        tk.src_tick = external_sync_select ? ext_rise_d_ff : ext_rise;
      end else begin
        tk.src_tick = gated_accumulate_enable ? tk.pin_lvl[sbt_pkg::PIN_GATE] : 1'b1;
      end
    end
  end

  assign tk.ps_sel = prescale_select;
  assign tk.ps_clr = !run_enable || ctrl_wr;

  // ==========================================================
  // count and period match
  assign match = tk.ps_tick && (count_ff == period_value_ff);

  // power-on reset only: the system wiring keeps other resets off rst_n_in
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_ff <= sbt_pkg::COUNT_RESET;
    end else if (count_wr) begin
      count_ff <= wdata_in;
    end else if (tk.ps_tick) begin
      count_ff <= match ? 16'h0000 : count_ff + 16'h0001;
    end
  end

  // ==========================================================
  // software registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_ff <= sbt_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_ff <= wdata_in & sbt_pkg::CTRL_WMASK;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      period_value_ff <= sbt_pkg::PERIOD_RESET;
    end else if (wr_in && (addr_in == sbt_pkg::ADDR_PERIOD)) begin
      period_value_ff <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mask_ff <= sbt_pkg::STATUS_RESET;
    end else if (wr_in && (addr_in == sbt_pkg::ADDR_MASK)) begin
      mask_ff <= wdata_in[1:0];
    end
  end

  // ==========================================================
  // sticky events, set beats a same-cycle clear
  assign ev_set[sbt_pkg::ST_MATCH] = match;
  assign ev_set[sbt_pkg::ST_GATE]  = (state_ff == sbt_pkg::ST_RUN) && !clock_source_select &&
                                     gated_accumulate_enable &&
                                     tk.pin_fall[sbt_pkg::PIN_GATE];
  assign ev_clr = (wr_in && (addr_in == sbt_pkg::ADDR_STATUS)) ? wdata_in[1:0] : 2'h0;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_ff <= sbt_pkg::STATUS_RESET;
    end else begin
      status_ff <= (status_ff & ~ev_clr) | ev_set;
    end
  end

  assign irq_out = |(status_ff & mask_ff);

  // ==========================================================
  // read port, data valid the cycle after rd_in
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 16'h0000;
    end else if (rd_in) begin
      case (addr_in)
        sbt_pkg::ADDR_CTRL:   rdata_ff <= ctrl_ff & sbt_pkg::CTRL_WMASK;
        sbt_pkg::ADDR_PERIOD: rdata_ff <= period_value_ff;
        sbt_pkg::ADDR_COUNT:  rdata_ff <= count_ff;
        sbt_pkg::ADDR_STATUS: rdata_ff <= {12'h000, state_ff, status_ff};
        sbt_pkg::ADDR_MASK:   rdata_ff <= {14'h0, mask_ff};
        default:              rdata_ff <= 16'h0000;
      endcase
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

  assign rdata_out = rdata_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_halt_when_off : assert property (
    !run_enable && !count_wr |=> $stable(count_ff))
    else $error("count moved while run_enable low");

  chk_match_wraps_zero : assert property (
    match && !count_wr |=> count_ff == 16'h0000)
    else $error("count did not return to zero after match");

  chk_match_sets_flag : assert property (
    match |=> status_ff[sbt_pkg::ST_MATCH])
    else $error("period match did not set status");

  chk_gate_fall_flag : assert property (
    ev_set[sbt_pkg::ST_GATE] |=> status_ff[sbt_pkg::ST_GATE])
    else $error("gate falling edge did not set status");

  // a mask write in the match cycle decides the next irq level itself, so that
  // cycle is left out rather than guessed
  chk_irq_follows_flag : assert property (
    match && mask_ff[sbt_pkg::ST_MATCH] && !(wr_in && addr_in == sbt_pkg::ADDR_MASK)
    |=> ##0 irq_out)
    else $error("masked-in match did not raise irq");

  chk_idle_stop_hold : assert property (
    run_enable && idle_in && stop_in_idle ##1 (idle_in && stop_in_idle && run_enable)
    |-> !tk.src_tick)
    else $error("timer ticked while stopped in idle");

  chk_gate_blocks_tick : assert property (
    !clock_source_select && gated_accumulate_enable && !tk.pin_lvl[sbt_pkg::PIN_GATE]
    |-> !tk.src_tick)
    else $error("gated timer ticked while gate low");

  chk_reserved_no_tick : assert property (
    clock_source_select && extended_clock_select == sbt_pkg::ECS_RSVD |-> !tk.src_tick)
    else $error("reserved clock select produced a tick");

  chk_ctrl_unimpl_zero : assert property (
    rd_in && addr_in == sbt_pkg::ADDR_CTRL |=> (rdata_out & ~sbt_pkg::CTRL_WMASK) == 16'h0000)
    else $error("unimplemented control bit read nonzero");

  chk_sync_latency : assert property (
    state_ff == sbt_pkg::ST_RUN && nxt_state == sbt_pkg::ST_RUN && clock_source_select &&
    !external_sync_select
    |-> tk.src_tick == ext_rise)
    else $error("unsynchronised counter tick misaligned");

  chk_sync_one_late : assert property (
    state_ff == sbt_pkg::ST_RUN && nxt_state == sbt_pkg::ST_RUN && clock_source_select &&
    external_sync_select && extended_clock_select == sbt_pkg::ECS_PIN && $stable(ctrl_ff)
    |-> tk.src_tick == $past(tk.pin_rise[sbt_pkg::PIN_EXT]))
    else $error("synchronised counter tick not one cycle behind pin");

  chk_status_w1c : assert property (
    wr_in && addr_in == sbt_pkg::ADDR_STATUS && wdata_in[sbt_pkg::ST_MATCH] && !match
    |=> !status_ff[sbt_pkg::ST_MATCH])
    else $error("written one did not clear match status");

  chk_sleep_hold : assert property (
    sleep_in && !(clock_source_select && !external_sync_select) |-> !tk.src_tick)
    else $error("timer ticked in sleep without an unsynchronised source");

  cov_match : cover property (match ##1 irq_out);
  cov_gate  : cover property (ev_set[sbt_pkg::ST_GATE]);
  cov_ext   : cover property (clock_source_select && tk.ps_tick);
  cov_hold  : cover property (state_ff == sbt_pkg::ST_HOLD);
  cov_sleep : cover property (sleep_in && tk.ps_tick);

endmodule : sbt_timer

// >>> hdl/sbt_pkg.sv
package sbt_pkg;

  // ==========================================================
  // register map, word index on addr_in
  localparam int unsigned ADDR_W      = 3;
  localparam int unsigned DATA_W      = 16;
  localparam logic [2:0]  ADDR_CTRL   = 3'h0;
  localparam logic [2:0]  ADDR_PERIOD = 3'h1;
  localparam logic [2:0]  ADDR_COUNT  = 3'h2;
  localparam logic [2:0]  ADDR_STATUS = 3'h3;
  localparam logic [2:0]  ADDR_MASK   = 3'h4;

  // ==========================================================
  // control register fields
  localparam int unsigned RUN_BIT   = 15;
  localparam int unsigned IDLE_BIT  = 13;
  localparam int unsigned ECS_LSB   = 8;
  localparam int unsigned GATE_BIT  = 6;
  localparam int unsigned PS_LSB    = 4;
  localparam int unsigned SYNC_BIT  = 2;
  localparam int unsigned CS_BIT    = 1;
  localparam logic [15:0] CTRL_WMASK   = 16'ha376;
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hffff;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;

  // ==========================================================
  // status and mask layout
  localparam int unsigned STATUS_W    = 2;
  localparam int unsigned ST_MATCH    = 0;
  localparam int unsigned ST_GATE     = 1;
  localparam logic [1:0]  STATUS_RESET = 2'h0;

  // ==========================================================
  // pins and prescaler
  localparam int unsigned NUM_PINS = 4;
  localparam int unsigned PIN_SECONDARY_OSC = 0;
  localparam int unsigned PIN_EXT  = 1;
  localparam int unsigned PIN_LOW_POWER_RC_OSC = 2;
  localparam int unsigned PIN_GATE = 3;
  localparam logic [7:0]  PS_TERM_1   = 8'h00;
  localparam logic [7:0]  PS_TERM_8   = 8'h07;
  localparam logic [7:0]  PS_TERM_64  = 8'h3f;
  localparam logic [7:0]  PS_TERM_256 = 8'hff;

  typedef enum logic [1:0] {
    ECS_SECONDARY_OSC = 2'b00,
    ECS_PIN  = 2'b01,
    ECS_LOW_POWER_RC_OSC = 2'b10,
    ECS_RSVD = 2'b11
  } sbt_ecs_t;

  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b11
  } sbt_state_t;

endpackage : sbt_pkg

// >>> hdl/sbt_tick_if.sv
`timescale 1ns/1ns
interface sbt_tick_if;
  logic [3:0] pin_rise;
  logic [3:0] pin_fall;
  logic [3:0] pin_lvl;
  logic       src_tick;
  logic [1:0] ps_sel;
  logic       ps_clr;
  logic       ps_tick;

  modport syncer (output pin_rise, output pin_fall, output pin_lvl);
  modport presc  (input src_tick, input ps_sel, input ps_clr, output ps_tick);
  modport core   (input pin_rise, input pin_fall, input pin_lvl, input ps_tick,
                  output src_tick, output ps_sel, output ps_clr);
endinterface : sbt_tick_if

// >>> hdl/sbt_pin_sync.sv
`timescale 1ns/1ns
module sbt_pin_sync (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic [3:0] pins_in,
  sbt_tick_if.syncer      tk
);
  // ==========================================================
  // two-stage synchroniser plus history stage per pin
  genvar g;
  generate
    for (g = 0; g < sbt_pkg::NUM_PINS; g++) begin : g_pin
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
          s3_ff <= 1'b0;
        end else begin
          s1_ff <= pins_in[g];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
        end
      end
      assign tk.pin_lvl[g]  = s2_ff;
      assign tk.pin_rise[g] = s2_ff & ~s3_ff;
      assign tk.pin_fall[g] = ~s2_ff & s3_ff;
    end
  endgenerate
endmodule : sbt_pin_sync

// >>> hdl/sbt_prescaler.sv
`timescale 1ns/1ns
module sbt_prescaler (
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  sbt_tick_if.presc tk
);
  logic [7:0] cnt_ff;
  logic [7:0] term;

  // ==========================================================
  // divide ratio select
  always_comb begin
    case (tk.ps_sel)
      2'b00:   term = sbt_pkg::PS_TERM_1;
      2'b01:   term = sbt_pkg::PS_TERM_8;
      2'b10:   term = sbt_pkg::PS_TERM_64;
      default: term = sbt_pkg::PS_TERM_256;
    endcase
  end

  assign tk.ps_tick = tk.src_tick & (cnt_ff == term);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_ff <= 8'h00;
    end else if (tk.ps_clr) begin
      cnt_ff <= 8'h00;
    end else if (tk.src_tick) begin
      cnt_ff <= (cnt_ff >= term) ? 8'h00 : cnt_ff + 8'h01;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_presc_div8_gap : assert property (
    (tk.ps_sel == 2'b01) && !tk.ps_clr && tk.ps_tick ##1 (!tk.ps_clr && tk.ps_sel == 2'b01)[*1]
    |-> cnt_ff == 8'h00)
    else $error("prescaler did not restart after output tick");
endmodule : sbt_prescaler

// >>> dv/sbt_osc_model.sv
`timescale 1ns/1ns
module sbt_osc_model (
  output logic secondary_osc_out,
  output logic ext_out,
  output logic low_power_rc_osc_out
);
  // ==========================================================
  // slow clock sources
  // clocks stand low between bursts, as a stopped oscillator would
  initial begin
    secondary_osc_out = 1'b0;
    ext_out  = 1'b0;
    low_power_rc_osc_out = 1'b0;
  end

  // code 11 pulses every line, but the test runs it in sleep with sync set, so a reserved select that counts is not caught
  task automatic burst(input logic [1:0] sel, input int n);
    // start away from the clock edge so a pin never races the synchroniser
    #20;
    repeat (n) begin
      secondary_osc_out = (sel == 2'h0) || (sel == 2'h3);
      ext_out  = (sel == 2'h1) || (sel == 2'h3);
      low_power_rc_osc_out = (sel == 2'h2) || (sel == 2'h3);
      #230;
      {secondary_osc_out, ext_out, low_power_rc_osc_out} = 3'h0;
      #270;
    end
  endtask : burst
endmodule : sbt_osc_model

// >>> dv/test_sixteen_bit_timer_rtc.sv
`timescale 1ns/1ns
module test_sixteen_bit_timer_rtc;
  logic        clk_in   = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        wr_in    = 1'b0;
  logic        rd_in    = 1'b0;
  logic [2:0]  addr_in  = 3'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic        idle_in  = 1'b0;
  logic        sleep_in = 1'b0;
  logic        gate_in  = 1'b0;
  logic [15:0] rdata_out;
  logic        irq_out;
  logic        secondary_osc;
  logic        ext_pin;
  logic        low_power_rc_osc;
  logic [15:0] v;
  int          failures    = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  int          t0;
  int          t1;
  int          p;
  int          n;
  int          ratio [4]   = '{1, 8, 64, 256};
  logic [15:0] rst_val [6] = '{16'h0000, 16'hffff, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

  always #50 clk_in = ~clk_in;

  sbt_osc_model src (.secondary_osc_out(secondary_osc), .ext_out(ext_pin), .low_power_rc_osc_out(low_power_rc_osc));

  sbt_timer dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .idle_in(idle_in),
    .sleep_in(sleep_in), .secondary_osc_in(secondary_osc), .external_clock_pin_in(ext_pin),
    .low_power_rc_osc_in(low_power_rc_osc), .gate_in(gate_in), .irq_out(irq_out)
  );

  // ==========================================================
  // bus and check tasks
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(posedge clk_in);
    d = rdata_out;
  endtask : rd

  // bounded poll; a miss shows up as a wrong interval
  task automatic wait_irq(output int t);
    int k;
    k = 0;
    do begin
      @(posedge clk_in);
      k++;
    end while (irq_out !== 1'b1 && k < 2000);
    t = cycles;
  endtask : wait_irq

  task automatic wrap_up;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // timeout
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end

  // ==========================================================
  // tests
  initial begin
    void'($urandom(32'h713eaa03));
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int a = 0; a < 6; a++) begin
      rd(3'(a), v);
      chk("reset value", v, rst_val[a]);
    end
    chk("irq after reset", {15'h0000, irq_out}, 16'h0000);
    wr(3'h0, 16'hffff);
    wr(3'h5, 16'h1234);
    rd(3'h0, v);
    chk("ctrl mask", v, 16'ha376);
    rd(3'h5, v);
    chk("unmapped", v, 16'h0000);
    rd(3'h2, v);
    chk("reserved source", v, 16'h0000);
    $display("test reset done");

    for (int ps = 0; ps < 4; ps++) begin
      p = (ps == 0) ? 3 + int'($urandom % 5) : 1;
      wr(3'h0, 16'h0000);
      wr(3'h1, 16'(p));
      wr(3'h2, 16'h0000);
      wr(3'h3, 16'h0003);
      wr(3'h4, 16'h0001);
      wr(3'h0, 16'h8000 | (16'(ps) << 4));
      wait_irq(t0);
      wr(3'h3, 16'h0001);
      wait_irq(t1);
      chk("match interval", 16'(t1 - t0), 16'((p + 1) * ratio[ps]));
      rd(3'h3, v);
      chk("match status", v, 16'h0005);
      rd(3'h2, v);
      chk("count bound", {15'h0000, v <= p}, 16'h0001);
    end
    wr(3'h4, 16'h0000);
    @(posedge clk_in);
    chk("irq masked", {15'h0000, irq_out}, 16'h0000);
    wr(3'h0, 16'h0000);
    wr(3'h2, 16'h0123);
    repeat (5) @(posedge clk_in);
    rd(3'h2, v);
    chk("stopped count", v, 16'h0123);
    wr(3'h3, 16'h0003);
    $display("test period done");

    wr(3'h2, 16'h0000);
    wr(3'h4, 16'h0002);
    wr(3'h1, 16'hffff);
    wr(3'h0, 16'h8040);
    repeat (10) @(posedge clk_in);
    rd(3'h2, v);
    chk("gate closed", v, 16'h0000);
    gate_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    gate_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    rd(3'h3, v);
    chk("gate event", v, 16'h0006);
    chk("gate irq", {15'h0000, irq_out}, 16'h0001);
    rd(3'h2, v);
    chk("gated count", {15'h0000, v != 16'h0000}, 16'h0001);
    wr(3'h3, 16'h0003);
    $display("test gate done");

    idle_in <= 1'b1;
    wr(3'h2, 16'h0000);
    wr(3'h0, 16'ha000);
    repeat (10) @(posedge clk_in);
    rd(3'h3, v);
    chk("idle hold", v, 16'h000c);
    rd(3'h2, v);
    chk("idle count", v, 16'h0000);
    wr(3'h0, 16'h8000);
    repeat (10) @(posedge clk_in);
    rd(3'h2, v);
    chk("runs in idle", {15'h0000, v != 16'h0000}, 16'h0001);
    idle_in <= 1'b0;
    $display("test idle done");

    // gating stays on with the gate low: an extended source must ignore it
    for (int e = 0; e < 4; e++) begin
      n = 3 + int'($urandom % 5);
      wr(3'h0, 16'h0000);
      wr(3'h2, 16'h0000);
      sleep_in <= (e != 1);
      wr(3'h0, 16'h8042 | (16'(e) << 8) | (16'(e % 2) << 2));
      src.burst(2'(e), n);
      repeat (8) @(posedge clk_in);
      sleep_in <= 1'b0;
      rd(3'h2, v);
      chk("extended count", v, (e == 3) ? 16'h0000 : 16'(n));
    end
    $display("test extended done");
    wrap_up();
  end
endmodule : test_sixteen_bit_timer_rtc
